// ---- ees_defs.vh ----
/*
 * Constants for the two-wire serial memory slave interface.
 * Assumes a 50 MHz system clock; included by its bare name.
 */
`ifndef EES_DEFS_VH
`define EES_DEFS_VH
`define EES_CLK_HZ          50000000
`define EES_PROG_TIME_MS    10
`define EES_PROG_CYCLES     ((`EES_CLK_HZ / 1000) * `EES_PROG_TIME_MS)
`define EES_PWRUP_TIME_MS   1
`define EES_TYPE_CODE       4'h0a
`define EES_TYPE_MSB        7
`define EES_TYPE_LSB        4
`define EES_RW_BIT          0
`define EES_ADDR_W          14
`define EES_PAGE_W          6
`define EES_MEM_RESET       8'h00
`endif

// ---- ees_skid.v ----
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes both sides run on the same clock as the buffer.
 */
`timescale 1ns/1ps
`default_nettype none
module ees_skid #(
  parameter W = 8
) (
  input  wire         ref_clk_in,
  input  wire         rst_in,
  input  wire [W-1:0] in_data_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  output wire [W-1:0] out_data_out,
  output wire         out_valid_out,
  input  wire         out_ready_in
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  // Honest full and empty flags from the occupancy count
  assign in_ready_out  = (cnt_q != 2'd2);
  assign out_valid_out = (cnt_q != 2'd0);
  assign out_data_out  = mem_q[rp_q];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // ----------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_in;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule
`default_nettype wire

// ---- ees_slave.v ----
/*
 * Two-wire serial slave of a byte-wide nonvolatile memory, with a
 * self-timed program cycle and a write-protect input.
 * Assumes SCL and SDA come straight from pins and are oversampled by
 * the 50 MHz clock; the SDA pin is resolved outside from the enable.
 */
// What this block does
// - Program cycle ends within 10 ms after STOP
// - Bus ignored, SDA released while programming
// - Device is slave only; master drives clock
// - SCL only input, times every bit
// - SDA driven open-drain: low or released
// - Protect high blocks programming whole array
// - Floating protect input counts as unprotected; wp_in has no pull-down here
// - SDA change with SCL high is condition
// - START is SDA fall with SCL high
// - Silent until a START is seen
// - STOP is SDA rise with SCL high
// - Address byte 1010, three don't-cares, R/W
// - Receiver acknowledges each byte, ninth clock
// - Protected: ack addresses, nack first data
// - Ack polling: nack while busy, ack after
`timescale 1ns/1ps
`default_nettype none
`include "ees_defs.vh"
module ees_slave #(
  parameter PROG_CYCLES = `EES_PROG_CYCLES,
  parameter ADDR_W      = `EES_ADDR_W,
  parameter PAGE_W      = `EES_PAGE_W
) (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_out,
  input  wire       wp_in,
  output wire       busy_out
);
  localparam DEPTH = 1 << ADDR_W;
  localparam PAGE  = 1 << PAGE_W;
  localparam [31:0] PROG_N = PROG_CYCLES;
  // Bus state machine
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEVA = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_RX   = 3'd3;
  localparam [2:0] ST_TX   = 3'd4;
  localparam [2:0] ST_MACK = 3'd5;
  localparam [2:0] ST_WAIT = 3'd6;

  reg [7:0]        mem_q [0:DEPTH-1];
  reg [7:0]        page_q [0:PAGE-1];
  reg [2:0]        scl_s_q;
  reg [2:0]        sda_s_q;
  reg [2:0]        wp_s_q;
  reg [2:0]        st_q;
  reg [3:0]        bit_q;
  reg [7:0]        sh_q;
  reg [1:0]        rxn_q;
  reg              rd_q;
  reg              ack_q;
  reg              drive_low_q;
  reg              wr_pend_q;
  reg              wp_lat_q;
  reg [ADDR_W-1:0] ptr_q;
  reg [ADDR_W-1:0] base_q;
  reg [PAGE_W:0]   nbytes_q;
  reg [PAGE_W:0]   pidx_q;
  reg [31:0]       pcnt_q;
  reg              prog_q;
  reg [7:0]        tx_q;

  wire scl_q = scl_s_q[1];
  wire sda_q = sda_s_q[1];
  // two-stage sync, edges from stage two and three
  wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
  wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
  wire start_ev = scl_q & scl_s_q[2] & ~sda_q & sda_s_q[2];
  wire stop_ev  = scl_q & scl_s_q[2] & sda_q & ~sda_s_q[2];

  // Received bytes stream through the buffer to the page latch
  wire [7:0] fb_data;
  wire       fb_valid;
  wire       fb_ready;
  wire       fb_push;
  wire       fb_in_ready;
  wire [7:0] rx_byte = {sh_q[6:0], sda_q};

  // slave only: SCL is never driven here
  // open-drain: output always low, enable only to pull
  assign sda_out    = 1'b0;
  assign sda_oe_out = drive_low_q;
  assign busy_out   = prog_q;
  // Page latch drains whenever the buffer holds a byte, never while programming
  assign fb_ready   = ~prog_q;
  assign fb_push    = (st_q == ST_RX) & scl_rise & (bit_q == 4'd7) &
                      (rxn_q == 2'd2) & ~wp_lat_q;

  ees_skid #(
    .W (8)
  ) u_rx_buf (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .in_data_in    (rx_byte),
    .in_valid_in   (fb_push),
    .in_ready_out  (fb_in_ready),
    .out_data_out  (fb_data),
    .out_valid_out (fb_valid),
    .out_ready_in  (fb_ready)
  );

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  // SCL sampled as input only; SCL and SDA idle high at reset, protect low
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
      wp_s_q  <= 3'b000;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      wp_s_q  <= {wp_s_q[1:0], wp_in};
    end
  end

  // ----------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------
  // The ack decision is made at the eighth rising edge, so SDA can be
  // pulled on the following fall without a combinational path.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q        <= ST_IDLE;
      bit_q       <= 4'd0;
      sh_q        <= 8'h00;
      rxn_q       <= 2'd0;
      rd_q        <= 1'b0;
      ack_q       <= 1'b0;
      drive_low_q <= 1'b0;
      wr_pend_q   <= 1'b0;
      wp_lat_q    <= 1'b0;
      ptr_q       <= {ADDR_W{1'b0}};
      base_q      <= {ADDR_W{1'b0}};
      nbytes_q    <= {(PAGE_W+1){1'b0}};
      tx_q        <= 8'h00;
    end else if (start_ev) begin
      // change while SCL high is a condition; wake on START
      st_q        <= ST_DEVA;
      bit_q       <= 4'd0;
      drive_low_q <= 1'b0;
      rxn_q       <= 2'd0;
      wr_pend_q   <= 1'b0;
    end else if (stop_ev) begin
      st_q        <= ST_IDLE;
      drive_low_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          drive_low_q <= 1'b0;
        end
        ST_DEVA, ST_RX: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 4'd1;
            if (bit_q == 4'd7) begin
              if (st_q == ST_DEVA) begin
                // type code match; no ack while busy
                ack_q <= (rx_byte[`EES_TYPE_MSB:`EES_TYPE_LSB] ==
                          `EES_TYPE_CODE) & ~prog_q;
                rd_q  <= rx_byte[`EES_RW_BIT];
                wp_lat_q <= wp_s_q[1];
                // A poll during the cycle must not empty the pending page
                if (~rx_byte[`EES_RW_BIT] & ~prog_q)
                  nbytes_q <= {(PAGE_W+1){1'b0}};
              end else if (rxn_q == 2'd0) begin
                ptr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
                ack_q <= 1'b1;
                rxn_q <= 2'd1;
              end else if (rxn_q == 2'd1) begin
                ptr_q[7:0] <= rx_byte;
                base_q <= {ptr_q[ADDR_W-1:8], rx_byte};
                ack_q <= 1'b1;
                rxn_q <= 2'd2;
              end else begin
                // protected array refuses the data byte
                ack_q <= ~wp_lat_q & fb_in_ready;
                if (~wp_lat_q & fb_in_ready) begin
                  wr_pend_q <= 1'b1;
                  if (nbytes_q != PAGE[PAGE_W:0])
                    nbytes_q <= nbytes_q + 1'b1;
                end
              end
            end
          end else if (scl_fall & (bit_q == 4'd8)) begin
            // pull SDA through the ninth clock
            drive_low_q <= ack_q;
            st_q        <= ack_q ? ST_ACK : ST_WAIT;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'd0;
            if (rd_q) begin
              tx_q        <= mem_q[ptr_q];
              drive_low_q <= ~mem_q[ptr_q][7];
              ptr_q       <= ptr_q + 1'b1;
              st_q        <= ST_TX;
            end else begin
              drive_low_q <= 1'b0;
              st_q        <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_q <= bit_q + 4'd1;
            if (bit_q == 4'd7) begin
              drive_low_q <= 1'b0;
              st_q        <= ST_MACK;
            end else begin
              drive_low_q <= ~tx_q[3'd6 - bit_q[2:0]];
            end
          end
        end
        ST_MACK: begin
          // Master ack on the ninth rise asks for the next byte
          if (scl_rise)
            st_q <= sda_q ? ST_WAIT : ST_ACK;
        end
        ST_WAIT: begin
          if (scl_fall)
            drive_low_q <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Page latch and self-timed program cycle
  // ----------------------------------------------------------
  // Page address wraps on its low bits; a 65th byte overwrites the first.
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      prog_q <= 1'b0;
      pcnt_q <= 32'd0;
      pidx_q <= {(PAGE_W+1){1'b0}};
    end else begin
      if (fb_valid & fb_ready) begin
        page_q[pidx_q[PAGE_W-1:0]] <= fb_data;
        pidx_q <= pidx_q + 1'b1;
      end
      // only unprotected bytes reach the latch
      if (stop_ev & wr_pend_q & ~prog_q) begin
        prog_q <= 1'b1;
        pcnt_q <= 32'd0;
      end else if (prog_q) begin
        // cycle finishes inside the program time
        if (pcnt_q == PROG_N - 32'd1) begin
          prog_q <= 1'b0;
          pidx_q <= {(PAGE_W+1){1'b0}};
        end else begin
          pcnt_q <= pcnt_q + 32'd1;
        end
      end
    end
  end

  // Array commit at the end of the cycle, a page row at a time
  integer k;
  always @(posedge ref_clk_in) begin
    if (prog_q & (pcnt_q == PROG_N - 32'd1)) begin
      for (k = 0; k < PAGE; k = k + 1) begin
        if (k < nbytes_q)
          mem_q[{base_q[ADDR_W-1:PAGE_W],
                 base_q[PAGE_W-1:0] + k[PAGE_W-1:0]}] <= page_q[k];
      end
    end
  end
endmodule
`default_nettype wire

// ---- ees_slave_properties.sv ----
/* Concurrent checks on the serial memory slave's pins.
   Assumes only the top ports of ees_slave; bound after the module. */
`timescale 1ns/1ps
`default_nettype none
module ees_slave_properties #(
  parameter PROG_CYCLES = 200
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic wp_in,
  input wire logic busy_out
);
  localparam int LIM = PROG_CYCLES + 8;
  logic        scl_q, sda_q, seen_q;
  logic [31:0] age_q;
  // ----
  // Pin level condition watch
  // ----
  // Age saturates, so a long idle never wraps into a young STOP
  always_ff @(posedge ref_clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (rst_in) begin
      seen_q <= 1'b0;
      age_q  <= 32'hffff_ffff;
    end else begin
      if (scl_in && scl_q && !sda_in && sda_q)
        seen_q <= 1'b1;
      if (scl_in && scl_q && sda_in && !sda_q)
        age_q <= 32'h0000_0000;
      else if (age_q != 32'hffff_ffff)
        age_q <= age_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  chk_drain_only: assert property (sda_out == 1'b0)
    else $error("data value not low");
  chk_busy_silent: assert property (busy_out |-> !sda_oe_out)
    else $error("drive while busy");
  chk_busy_on_stop: assert property ($rose(busy_out) |-> age_q < 8)
    else $error("busy without STOP");
  chk_prog_bound: assert property (busy_out |-> age_q <= LIM)
    else $error("program cycle too long");
  chk_drive_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("drive began with SCL high");
  chk_hold_scl_high: assert property (scl_in && $past(scl_in) |->
    $stable(sda_oe_out)) else $error("data moved with SCL high");
  chk_quiet_no_start: assert property (!seen_q |-> !sda_oe_out)
    else $error("drive before START");
  chk_protect_block: assert property ($rose(busy_out) |-> !wp_in)
    else $error("programming while protected");
  chk_ack_stands: assert property ($rose(sda_oe_out) |=> sda_oe_out[*5])
    else $error("drive too short");
endmodule
bind ees_slave ees_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .wp_in(wp_in), .busy_out(busy_out));
`default_nettype wire

// ---- ees_mst.sv ----
/* Bus master model for the serial memory slave.
   Assumes the bench resolves SDA with a pull-up and feeds it back. */
`timescale 1ns/1ps
`default_nettype none
module ees_mst (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_low_out
);
  // master owns SCL; idle high and released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Quarter bit, moved on falling edges only
  task automatic q;
    repeat (2) @(negedge ref_clk_in);
  endtask
  // start from idle or SCL low
  task automatic start;
    sda_low_out = 1'b0;
    q;
    scl_out = 1'b1;
    q;
    sda_low_out = 1'b1;
    q;
    scl_out = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    q;
    scl_out = 1'b1;
    q;
    sda_low_out = 1'b0;
    q;
  endtask
  // data moves only while SCL is low
  task automatic bit_x(input logic b, output logic r);
    sda_low_out = ~b;
    q;
    scl_out = 1'b1;
    q;
    r = sda_in;
    q;
    scl_out = 1'b0;
    q;
  endtask
  // ninth bit: m is the master's own answer
  task automatic byte_x(input logic [7:0] d, input logic m,
                        output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(m, a);
    ack = ~a;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* Self-checking bench for the serial memory slave and its buffer.
   Assumes ees_slave, ees_skid, ees_mst and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PROG = 200;
  logic       clk, rst, wp;
  wire        scl, mlow, sda_w, oe, sdo, busy;
  int         failures = 0, checks = 0, cyc = 0;
  // Open-drain wire with pull-up
  assign sda_w = ~(mlow | (oe & ~sdo));
  ees_slave #(.PROG_CYCLES(PROG)) i_ees_slave (.ref_clk_in(clk),
    .rst_in(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sdo),
    .sda_oe_out(oe), .wp_in(wp), .busy_out(busy));
  ees_mst i_ees_mst (.ref_clk_in(clk), .sda_in(sda_w), .scl_out(scl),
    .sda_low_out(mlow));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // START, write address with odd don't-cares, two address bytes
  task automatic sel(input logic [15:0] a);
    logic [7:0] r;
    logic       k;
    i_ees_mst.start;
    i_ees_mst.byte_x(8'hae, 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.byte_x(a[15:8], 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.byte_x(a[7:0], 1'b1, r, k);
    chk(k, 8'h01);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic       k;
    sel(a);
    i_ees_mst.start;
    i_ees_mst.byte_x(8'haf, 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.byte_x(8'hff, 1'b1, r, k);
    chk(r, e);
    i_ees_mst.stop;
  endtask
  // Bits before any START, then a wrong type code
  task automatic t_nostart;
    logic [7:0] r;
    logic       k;
    i_ees_mst.byte_x(8'hae, 1'b1, r, k);
    chk(k, 8'h00);
    i_ees_mst.start;
    i_ees_mst.byte_x(8'h5e, 1'b1, r, k);
    chk(k, 8'h00);
    i_ees_mst.stop;
  endtask
  // Page write across the wrap point, poll while busy and after
  task automatic t_write;
    logic [7:0] r;
    logic       k;
    int         n;
    wp = 1'b0;
    sel(16'h013f);
    i_ees_mst.byte_x(8'h5a, 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.byte_x(8'hc3, 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.stop;
    repeat (6) @(negedge clk);
    chk(busy, 8'h01);
    i_ees_mst.start;
    i_ees_mst.byte_x(8'hae, 1'b1, r, k);
    chk(k, 8'h00);
    i_ees_mst.stop;
    for (n = 0; busy === 1'b1 && n < PROG; n++)
      @(negedge clk);
    chk(busy, 8'h00);
    i_ees_mst.start;
    i_ees_mst.byte_x(8'hae, 1'b1, r, k);
    chk(k, 8'h01);
    i_ees_mst.stop;
    rd(16'h013f, 8'h5a);
    rd(16'h0100, 8'hc3);
  endtask
  // Protected write: addresses taken, data refused, array kept
  task automatic t_wp;
    logic [7:0] r;
    logic       k;
    wp = 1'b1;
    sel(16'h013f);
    i_ees_mst.byte_x(8'h00, 1'b1, r, k);
    chk(k, 8'h00);
    i_ees_mst.stop;
    repeat (8) @(negedge clk);
    chk(busy, 8'h00);
    wp = 1'b0;
    rd(16'h013f, 8'h5a);
  endtask
  // Four bytes through the receive buffer, read back in order with
  // master acks, so the buffer and the sequential read are both seen
  task automatic t_burst;
    logic [7:0] r;
    logic       k;
    wp = 1'b0;
    sel(16'h0200);
    for (int i = 0; i < 4; i++) begin
      i_ees_mst.byte_x(8'h11 << i, 1'b1, r, k);
      chk(k, 8'h01);
    end
    i_ees_mst.stop;
    repeat (4) @(negedge clk);
    chk(busy, 8'h01);
    for (int n = 0; busy === 1'b1 && n < PROG; n++)
      @(negedge clk);
    sel(16'h0200);
    i_ees_mst.start;
    i_ees_mst.byte_x(8'haf, 1'b1, r, k);
    chk(k, 8'h01);
    for (int i = 0; i < 4; i++) begin
      i_ees_mst.byte_x(8'hff, i == 3, r, k);
      chk(r, 8'h11 << i);
    end
    i_ees_mst.stop;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_nostart;
    t_write;
    t_wp;
    t_burst;
    close_out;
  end
endmodule
`default_nettype wire
